// file: common/sdn_pkg.sv
package sdn_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_IRQ_FLAGS = 6'h06;
  localparam logic [5:0] IDX_IRQ_ENABLES = 6'h07;
  localparam logic [5:0] IDX_RESULT_HIGH = 6'h10;
  localparam logic [5:0] IDX_RESULT_LOW = 6'h11;
  localparam logic [5:0] IDX_RESULT_EXTRA = 6'h12;
  localparam logic [5:0] IDX_CONV_CONTROL = 6'h13;
  localparam logic [5:0] IDX_CHOPPER = 6'h15;
  localparam logic [5:0] IDX_INPUT_ROUTING = 6'h18;
  localparam logic [5:0] IDX_REF_ROUTING = 6'h19;
  localparam logic [5:0] IDX_CONV_SETUP = 6'h1a;
  localparam logic [5:0] IDX_AMP_SETUP = 6'h1b;
  // implemented-bit masks; other bits read as zero
  localparam logic [7:0] MASK_IRQ_FLAGS = 8'h04;
  localparam logic [7:0] MASK_IRQ_ENABLES = 8'h84;
  localparam logic [7:0] MASK_CONV_CONTROL = 8'h0f;
  localparam logic [7:0] MASK_CHOPPER = 8'h0c;
  localparam logic [7:0] MASK_INPUT_ROUTING = 8'hff;
  localparam logic [7:0] MASK_REF_ROUTING = 8'h3f;
  localparam logic [7:0] MASK_CONV_SETUP = 8'h8f;
  localparam logic [7:0] MASK_AMP_SETUP = 8'h0f;
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions
  localparam int DONE_BIT = 2;
  localparam int GIE_BIT = 7;
  localparam int COMB_EN_BIT = 3;
  localparam int RATE_LSB = 0;
  localparam int CHOP_LSB = 2;
  localparam int CONV_EN_BIT = 1;
  localparam int SHORT_BIT = 0;
  // chopper codes
  localparam logic [1:0] CHOP_SLOW = 2'h3;
  localparam logic [1:0] CHOP_FAST = 2'h2;
  localparam logic [1:0] CHOP_NEG = 2'h1;
  // chopper divisors of the system clock
  localparam logic [9:0] CHOP_DIV_SLOW = 10'h3e8;
  localparam logic [9:0] CHOP_DIV_FAST = 10'h1f4;
  // output rate divisors of the sample clock, codes 0..6; code 7 as 6
  localparam logic [12:0] RATE_DIV_0 = 13'h007d;
  localparam logic [12:0] RATE_DIV_1 = 13'h00fa;
  localparam logic [12:0] RATE_DIV_2 = 13'h01f4;
  localparam logic [12:0] RATE_DIV_3 = 13'h03e8;
  localparam logic [12:0] RATE_DIV_4 = 13'h07d0;
  localparam logic [12:0] RATE_DIV_5 = 13'h0fa0;
  localparam logic [12:0] RATE_DIV_6 = 13'h1f40;
  // conversion sequencer states
  typedef enum logic [2:0] {
    CONV_IDLE = 3'b001,
    CONV_RUN = 3'b010,
    CONV_DONE = 3'b100
  } sdn_conv_state_type;
  // controls toward the analog network
  typedef struct packed {
    logic [1:0] negative_input_select;
    logic [2:0] filter_input_select;
    logic filter_path_select;
    logic [1:0] positive_input_select;
    logic [1:0] amp_inverting_select;
    logic [1:0] ref_negative_select;
    logic [1:0] ref_positive_select;
    logic internal_reference_enable;
    logic [1:0] converter_gain_select;
    logic converter_enable;
    logic input_short_zero;
    logic amplifier_power_enable;
    logic [2:0] amp_noninverting_select;
  } sdn_analog_type;
endpackage : sdn_pkg

// file: rtl/sdn_network_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - 14-bit result from input/reference ratio
// - fully differential input and reference pairs
// - 16-bit read-only result over two bytes
// - bits 15 and 14 carry sign
// - third byte holds the low byte of the ones count
// - comb enable clear forces result zero
// - rate field divides sample clock 125..8000
// - chopper runs at clock/1000 or clock/500
// - chopping stopped, fixed offset orientation
// - negative input select routing
// - filter input select routing
// - filter path bit enables low-pass filter
// - positive input select routing
// - converter enable bit switches converter
// - input short ties both inputs negative
module sdn_network_ctrl #(
  parameter int RESULT_W = 14
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic sample_tick_in,
  input wire logic mod_bit_in,
  output sdn_pkg::sdn_analog_type analog_out,
  output logic chop_phase_out,
  output logic result_valid_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////
  // reset synchroniser
  logic rst_meta_q; // first stage, read only by second
  logic rstn_q; // released copy for the design

  // async assert, two-flop release
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_q <= 1'b0;
      rstn_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rstn_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register storage
  // eight-bit registers; only the low byte lane carries data
  logic [7:0] irq_flags_q; // sticky status
  logic [7:0] irq_enables_q; // mask plus global enable
  logic [7:0] conv_control_q; // comb enable and rate
  logic [7:0] chopper_q; // chopper mode
  logic [7:0] input_routing_q; // input multiplexers
  logic [7:0] ref_routing_q; // reference multiplexers
  logic [7:0] conv_setup_q; // enable, gain, short
  logic [7:0] amp_setup_q; // amplifier setup
  logic [7:0] result_high_q; // result bits 15..8
  logic [7:0] result_low_q; // result bits 7..0
  logic [7:0] result_extra_q; // extension byte

  // bus decode
  logic bus_req; // live request
  logic wr_lane0; // write on the byte lane used
  logic [5:0] reg_idx; // word index
  logic done_pulse; // conversion completed this cycle

  // a request is taken while ack is low; the ack that follows ends it
  assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  // writes land on the edge where the master sees ack, not a cycle
  // before it, so a master that gives up early leaves registers alone
  assign wr_lane0 = wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in && wb_sel_in[0];
  // byte address low bits ignored; registers sit one per word
  assign reg_idx = wb_adr_in[7:2];

  ////////////////////////////////////////////////////////////////////
  // wishbone answer: one wait state, every address acked
  always_ff @(posedge clock_in or negedge rstn_q) begin
    if (!rstn_q) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= bus_req;
    end
  end

  // read mux, registered so data and ack line up
  // reserved bits were masked on write, so each register reads as stored
  always_ff @(posedge clock_in or negedge rstn_q) begin
    if (!rstn_q) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (bus_req && !wb_we_in) begin
      case (reg_idx)
        sdn_pkg::IDX_IRQ_FLAGS: begin
          wb_dat_out <= {24'h00_0000, irq_flags_q};
        end
        sdn_pkg::IDX_IRQ_ENABLES: begin
          wb_dat_out <= {24'h00_0000, irq_enables_q};
        end
        sdn_pkg::IDX_RESULT_HIGH: begin
          wb_dat_out <= {24'h00_0000, result_high_q};
        end
        sdn_pkg::IDX_RESULT_LOW: begin
          wb_dat_out <= {24'h00_0000, result_low_q};
        end
        sdn_pkg::IDX_RESULT_EXTRA: begin
          wb_dat_out <= {24'h00_0000, result_extra_q};
        end
        sdn_pkg::IDX_CONV_CONTROL: begin
          wb_dat_out <= {24'h00_0000, conv_control_q};
        end
        sdn_pkg::IDX_CHOPPER: begin
          wb_dat_out <= {24'h00_0000, chopper_q};
        end
        sdn_pkg::IDX_INPUT_ROUTING: begin
          wb_dat_out <= {24'h00_0000, input_routing_q};
        end
        sdn_pkg::IDX_REF_ROUTING: begin
          wb_dat_out <= {24'h00_0000, ref_routing_q};
        end
        sdn_pkg::IDX_CONV_SETUP: begin
          wb_dat_out <= {24'h00_0000, conv_setup_q};
        end
        sdn_pkg::IDX_AMP_SETUP: begin
          wb_dat_out <= {24'h00_0000, amp_setup_q};
        end
        default: begin
          wb_dat_out <= 32'h0000_0000; // unmapped reads zero
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configuration registers; result bytes ignore writes
  // masks drop unimplemented bits at the door, keeping controls clean
  always_ff @(posedge clock_in or negedge rstn_q) begin
    if (!rstn_q) begin
      irq_enables_q <= sdn_pkg::REG_RESET;
      conv_control_q <= sdn_pkg::REG_RESET;
      chopper_q <= sdn_pkg::REG_RESET;
      input_routing_q <= sdn_pkg::REG_RESET;
      ref_routing_q <= sdn_pkg::REG_RESET;
      conv_setup_q <= sdn_pkg::REG_RESET;
      amp_setup_q <= sdn_pkg::REG_RESET;
    end else if (wr_lane0) begin
      case (reg_idx)
        sdn_pkg::IDX_IRQ_ENABLES: begin
          irq_enables_q <= wb_dat_in[7:0] & sdn_pkg::MASK_IRQ_ENABLES;
        end
        sdn_pkg::IDX_CONV_CONTROL: begin
          conv_control_q <= wb_dat_in[7:0] & sdn_pkg::MASK_CONV_CONTROL;
        end
        sdn_pkg::IDX_CHOPPER: begin
          chopper_q <= wb_dat_in[7:0] & sdn_pkg::MASK_CHOPPER;
        end
        sdn_pkg::IDX_INPUT_ROUTING: begin
          input_routing_q <= wb_dat_in[7:0] & sdn_pkg::MASK_INPUT_ROUTING;
        end
        sdn_pkg::IDX_REF_ROUTING: begin
          ref_routing_q <= wb_dat_in[7:0] & sdn_pkg::MASK_REF_ROUTING;
        end
        sdn_pkg::IDX_CONV_SETUP: begin
          conv_setup_q <= wb_dat_in[7:0] & sdn_pkg::MASK_CONV_SETUP;
        end
        sdn_pkg::IDX_AMP_SETUP: begin
          amp_setup_q <= wb_dat_in[7:0] & sdn_pkg::MASK_AMP_SETUP;
        end
        default: begin
          // other indices hold nothing writable
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sticky done flag, write one to clear; set wins over clear
  // a done strobe landing on the clearing write must not be lost,
  // so software never misses a conversion
  logic flag_clear; // software clear this cycle

  assign flag_clear = wr_lane0 && (reg_idx == sdn_pkg::IDX_IRQ_FLAGS)
    && wb_dat_in[sdn_pkg::DONE_BIT];

  always_ff @(posedge clock_in or negedge rstn_q) begin
    if (!rstn_q) begin
      irq_flags_q <= sdn_pkg::REG_RESET;
    end else if (done_pulse) begin
      irq_flags_q[sdn_pkg::DONE_BIT] <= 1'b1;
    end else if (flag_clear) begin
      irq_flags_q[sdn_pkg::DONE_BIT] <= 1'b0;
    end
  end

  // level request gated by both enables
  // combinational so the request drops in the cycle the clear lands
  assign irq_out = irq_flags_q[sdn_pkg::DONE_BIT]
    && irq_enables_q[sdn_pkg::DONE_BIT]
    && irq_enables_q[sdn_pkg::GIE_BIT];

  ////////////////////////////////////////////////////////////////////
  // analog network controls straight from the registers
  // no extra flop: the network sees a setting the cycle after the
  // write, and reset drives every field to its zero code
  always_comb begin
    analog_out.negative_input_select = input_routing_q[7:6];
    analog_out.filter_input_select = input_routing_q[5:3];
    analog_out.filter_path_select = input_routing_q[2];
    analog_out.positive_input_select = input_routing_q[1:0];
    analog_out.amp_inverting_select = ref_routing_q[5:4];
    analog_out.ref_negative_select = ref_routing_q[3:2];
    analog_out.ref_positive_select = ref_routing_q[1:0];
    analog_out.internal_reference_enable = conv_setup_q[7];
    analog_out.converter_gain_select = conv_setup_q[3:2];
    analog_out.converter_enable = conv_setup_q[sdn_pkg::CONV_EN_BIT];
    analog_out.input_short_zero = conv_setup_q[sdn_pkg::SHORT_BIT];
    analog_out.amplifier_power_enable = amp_setup_q[3];
    analog_out.amp_noninverting_select = amp_setup_q[2:0];
  end

  ////////////////////////////////////////////////////////////////////
  // chopper divider on the system clock
  logic [1:0] chop_mode; // chopper field
  logic [9:0] chop_half; // half period in clocks
  logic [9:0] chop_cnt_q; // position in half period
  logic chopping; // divider active

  assign chop_mode = chopper_q[sdn_pkg::CHOP_LSB +: 2];
  assign chopping = chop_mode[1];
  assign chop_half = (chop_mode == sdn_pkg::CHOP_SLOW) ?
    (sdn_pkg::CHOP_DIV_SLOW >> 1) : (sdn_pkg::CHOP_DIV_FAST >> 1);

  // half-period counter, restarts when chopping stops
  // comparing with >= lets a slow to fast switch end a long half at once
  always_ff @(posedge clock_in or negedge rstn_q) begin
    if (!rstn_q) begin
      chop_cnt_q <= 10'h000;
    end else if (!chopping || (chop_cnt_q >= chop_half - 10'h001)) begin
      chop_cnt_q <= 10'h000;
    end else begin
      chop_cnt_q <= chop_cnt_q + 10'h001;
    end
  end

  // phase toggles each half period; fixed when stopped
  always_ff @(posedge clock_in or negedge rstn_q) begin
    if (!rstn_q) begin
      chop_phase_out <= 1'b0;
    end else if (!chopping) begin
      chop_phase_out <= (chop_mode == sdn_pkg::CHOP_NEG);
    end else if (chop_cnt_q >= chop_half - 10'h001) begin
      chop_phase_out <= !chop_phase_out;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // decimation: counts modulator ones over a rate period
  // plain ones count, not a sinc filter: cheap and exact for a steady
  // input, but it passes more quantisation noise than a comb would
  // a rate change takes effect within the period already running
  logic comb_en; // comb filter enabled
  logic conv_on; // converter running
  logic [12:0] rate_div; // samples per result
  logic [12:0] samp_cnt_q; // samples taken this period
  logic [12:0] ones_q; // ones seen this period
  logic [12:0] ones_final; // ones including this sample
  logic period_end; // last sample of the period
  sdn_pkg::sdn_conv_state_type state_q;

  assign comb_en = conv_control_q[sdn_pkg::COMB_EN_BIT];
  assign conv_on = comb_en && conv_setup_q[sdn_pkg::CONV_EN_BIT];

  // rate code to divisor; code 7 repeats code 6
  always_comb begin
    case (conv_control_q[sdn_pkg::RATE_LSB +: 3])
      3'h0: rate_div = sdn_pkg::RATE_DIV_0;
      3'h1: rate_div = sdn_pkg::RATE_DIV_1;
      3'h2: rate_div = sdn_pkg::RATE_DIV_2;
      3'h3: rate_div = sdn_pkg::RATE_DIV_3;
      3'h4: rate_div = sdn_pkg::RATE_DIV_4;
      3'h5: rate_div = sdn_pkg::RATE_DIV_5;
      default: rate_div = sdn_pkg::RATE_DIV_6;
    endcase
  end

  assign period_end = sample_tick_in && (samp_cnt_q == rate_div - 13'h0001);
  assign ones_final = ones_q + {12'h000, mod_bit_in};
  assign done_pulse = (state_q == sdn_pkg::CONV_DONE);
  assign result_valid_out = done_pulse;

  // sequencer: idle while off, run, one-cycle done
  // done lasts one cycle so flag and strobe fire once per result
  always_ff @(posedge clock_in or negedge rstn_q) begin
    if (!rstn_q) begin
      state_q <= sdn_pkg::CONV_IDLE;
    end else begin
      case (state_q)
        sdn_pkg::CONV_IDLE: begin
          if (conv_on) begin
            state_q <= sdn_pkg::CONV_RUN;
          end
        end
        sdn_pkg::CONV_RUN: begin
          if (!conv_on) begin
            state_q <= sdn_pkg::CONV_IDLE;
          end else if (period_end) begin
            state_q <= sdn_pkg::CONV_DONE;
          end
        end
        sdn_pkg::CONV_DONE: begin
          state_q <= conv_on ? sdn_pkg::CONV_RUN : sdn_pkg::CONV_IDLE;
        end
        default: begin
          state_q <= sdn_pkg::CONV_IDLE;
        end
      endcase
    end
  end

  // sample and ones counters; cleared outside a run
  // the last tick of a period is folded in through ones_final
  always_ff @(posedge clock_in or negedge rstn_q) begin
    if (!rstn_q) begin
      samp_cnt_q <= 13'h0000;
      ones_q <= 13'h0000;
    end else if (state_q == sdn_pkg::CONV_IDLE || !conv_on || period_end) begin
      samp_cnt_q <= 13'h0000;
      ones_q <= 13'h0000;
    end else if (sample_tick_in) begin
      samp_cnt_q <= samp_cnt_q + 13'h0001;
      ones_q <= ones_final;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // result: 2*ones - N, signed ratio scaled to the period
  // a ratio of all ones gives +N, all zeros -N; 8000 fits 14 bits
  logic [15:0] diff; // signed result of the period
  logic [RESULT_W-1:0] magnitude; // data bits 13..0
  logic sign; // negative result

  assign diff = {2'b00, ones_final, 1'b0} - {3'b000, rate_div};
  assign sign = diff[15];
  assign magnitude = diff[RESULT_W-1:0];

  // all three bytes update together; zero while comb is off
  // the doubled sign keeps the high byte sign-extended even when
  // the magnitude reaches its top bit
  always_ff @(posedge clock_in or negedge rstn_q) begin
    if (!rstn_q) begin
      result_high_q <= sdn_pkg::REG_RESET;
      result_low_q <= sdn_pkg::REG_RESET;
      result_extra_q <= sdn_pkg::REG_RESET;
    end else if (!comb_en) begin
      result_high_q <= 8'h00;
      result_low_q <= 8'h00;
      result_extra_q <= 8'h00;
    end else if (state_q == sdn_pkg::CONV_RUN && conv_on && period_end) begin
      result_high_q <= {sign, sign, magnitude[13:8]};
      result_low_q <= magnitude[7:0];
      result_extra_q <= ones_final[7:0];
    end
  end

endmodule : sdn_network_ctrl

// file: test/sdn_ctrl_checker.sv
`timescale 1ns/1ps
// pin-level timing of bus, result strobe and interrupt
module sdn_ctrl_checker #(
  parameter int RESULT_W = 14
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic sample_tick_in,
  input wire logic mod_bit_in,
  input wire sdn_pkg::sdn_analog_type analog_out,
  input wire logic chop_phase_out,
  input wire logic result_valid_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);
  logic [1:0] since_tick_q; // cycles since last tick
  logic wr_ack; // a write being acknowledged
  assign wr_ack = wb_ack_out & wb_we_in;
  // saturates so a long gap never wraps back to a small count
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) since_tick_q <= 2'h3;
    else if (sample_tick_in) since_tick_q <= 2'h0;
    else if (since_tick_q != 2'h3) since_tick_q <= since_tick_q + 2'h1;
  end
  ////////////////////////////////////////
  chk_ack_one_wait: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing after request");
  chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  chk_read_upper: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  chk_data_hold: assert property ($changed(wb_dat_out) |-> wb_ack_out && !wb_we_in)
    else $error("read data moved outside a read");
  chk_valid_pulse: assert property (result_valid_out |=> !result_valid_out)
    else $error("result strobe too long");
  chk_valid_tick: assert property (result_valid_out |-> since_tick_q <= 2'h1)
    else $error("result strobe without sample tick");
  chk_irq_fall: assert property ($fell(irq_out) |-> wr_ack || $past(wr_ack))
    else $error("interrupt dropped without a write");
  chk_irq_rise: assert property ($rose(irq_out) |-> wr_ack || $past(wr_ack) ||
    result_valid_out || $past(result_valid_out) || $past(result_valid_out, 2))
    else $error("interrupt rose without cause");
  chk_analog_write: assert property ($changed(analog_out) |-> $past(wr_ack))
    else $error("analog controls moved without a write");
  cov_result: cover property (result_valid_out);
  cov_irq: cover property ($rose(irq_out));
  cov_chop: cover property ($changed(chop_phase_out));
endmodule : sdn_ctrl_checker

bind sdn_network_ctrl sdn_ctrl_checker #(.RESULT_W(RESULT_W)) i_sdn_ctrl_checker (
  .clock_in(clock_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .sample_tick_in(sample_tick_in),
  .mod_bit_in(mod_bit_in), .analog_out(analog_out), .chop_phase_out(chop_phase_out),
  .result_valid_out(result_valid_out), .irq_out(irq_out)
);

// file: test/sdn_mod_model.sv
`timescale 1ns/1ps
// modulator stand-in: a tick every clock while running, ones density from the bench
module sdn_mod_model (
  input wire logic clock_in,
  input wire logic run_in,
  input wire logic [3:0] density_in,
  output logic tick_out,
  output logic bit_out
);
  logic tick_q = 1'b0;
  logic bit_q = 1'b0;
  logic [15:0] idx_q = 16'h0000; // ticks since run start
  assign tick_out = tick_q;
  assign bit_out = bit_q;
  // bit is only meaningful with a tick; it toggles otherwise so no stale level is read
  always_ff @(posedge clock_in) begin
    tick_q <= run_in;
    if (run_in) bit_q <= {1'b0, idx_q[2:0]} < density_in;
    else bit_q <= ~bit_q;
    if (!run_in) idx_q <= 16'h0000;
    else idx_q <= idx_q + 16'h0001;
  end
endmodule : sdn_mod_model

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cyc = 1'b0; // cyc and stb share one strobe
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, tick, mbit, chop, valid, irq;
  logic run = 1'b0; // starts the modulator model
  logic [3:0] dens = 4'h0; // ones per eight ticks
  sdn_pkg::sdn_analog_type ana;
  int miscompares = 0;
  int samples_checked = 0;
  int seed = 32'h0000_141a;
  logic [31:0] exp_q[$]; // expected read data, oldest first
  // flags, enables, result high/low/extra, control, chopper, routing x2, setup x2
  logic [5:0] idx_tab[11] = '{6'h06, 6'h07, 6'h10, 6'h11, 6'h12, 6'h13, 6'h15, 6'h18,
    6'h19, 6'h1a, 6'h1b};
  logic [7:0] msk_tab[11] = '{8'h04, 8'h84, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h0c, 8'hff,
    8'h3f, 8'h8f, 8'h0f};
  int div_tab[8] = '{125, 250, 500, 1000, 2000, 4000, 8000, 8000};

  initial forever #5 clock_in = ~clock_in;

  sdn_network_ctrl i_sdn_network_ctrl (
    .clock_in(clock_in), .rstn_in(rstn_in), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .sample_tick_in(tick), .mod_bit_in(mbit), .analog_out(ana), .chop_phase_out(chop),
    .result_valid_out(valid), .irq_out(irq)
  );
  sdn_mod_model i_sdn_mod_model (
    .clock_in(clock_in), .run_in(run), .density_in(dens), .tick_out(tick), .bit_out(mbit)
  );
  ////////////////////////////////////////
  task automatic check(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : check

  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // one classic cycle; a read queues its expected data for the monitor
  task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d, input logic [7:0] e);
    int n;
    if (!w) exp_q.push_back({24'h00_0000, e});
    cyc <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= {i, 2'b00};
    wdat <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    cyc <= 1'b0;
    @(posedge clock_in);
  endtask : wb

  // edges until the next result strobe; bounded
  task automatic wait_valid(int lim, output int n);
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (valid !== 1'b1 && n < lim);
    if (n >= lim) miscompares++;
  endtask : wait_valid

  // first change may be a leftover of the old code, so time change to change
  task automatic chop_gap(int e);
    int n;
    logic p;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      p = chop;
      while (chop === p && n < 2000) begin
        @(posedge clock_in);
        n++;
      end
    end
    check("chop gap", 32'(e), 32'(n));
  endtask : chop_gap

  function automatic int count_ones(int s, int n, int d);
    int c;
    c = 0;
    for (int k = s; k < s + n; k++) if ((k % 8) < d) c++;
    return c;
  endfunction : count_ones

  // monitor: every read acknowledge takes the oldest note
  always @(posedge clock_in) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) check("spare read", 32'h0000_0001, 32'h0000_0000);
      else check("read", exp_q.pop_front(), rdat);
    end
  end

  // hang guard; the full run needs about 50000 cycles
  initial begin
    repeat (100000) @(posedge clock_in);
    miscompares++;
    tally_and_finish();
  end
  ////////////////////////////////////////
  initial begin
    int d, n, ones;
    logic [15:0] r;
    logic [7:0] v;
    repeat (6) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    for (int k = 0; k < 11; k++) wb(1'b0, idx_tab[k], 8'h00, 8'h00);
    wb(1'b0, 6'h3f, 8'h00, 8'h00);
    check("analog", 32'h0000_0000, 32'(ana));
    // random writes; result bytes must stay read-only
    repeat (3) begin
      for (int k = 1; k < 11; k++) begin
        v = 8'($random(seed));
        wb(1'b1, idx_tab[k], v, 8'h00);
        wb(1'b0, idx_tab[k], 8'h00, v & msk_tab[k]);
        // ana[22:15] is the routing byte field by field
        if (k == 7) check("routing", 32'(v), 32'(ana[22:15]));
        if (k == 8) check("refs", 32'(v[5:0]), 32'(ana[14:9]));
        if (k == 9) check("setup", 32'({v[7], v[3:0]}), 32'(ana[8:4]));
        if (k == 10) check("amp", 32'(v[3:0]), 32'(ana[3:0]));
      end
    end
    wb(1'b1, idx_tab[6], 8'h0c, 8'h00);
    chop_gap(500);
    wb(1'b1, idx_tab[6], 8'h08, 8'h00);
    chop_gap(250);
    for (int k = 1; k >= 0; k--) begin
      wb(1'b1, idx_tab[6], 8'(k * 4), 8'h00);
      repeat (300) @(posedge clock_in);
      check("chop hold", 32'(k), 32'(chop));
    end
    // conversion at the fastest rate, global enable on then off
    d = $random(seed) & 7;
    dens <= 4'(d);
    wb(1'b1, idx_tab[1], 8'h84, 8'h00);
    wb(1'b1, idx_tab[5], 8'h08, 8'h00);
    wb(1'b1, idx_tab[9], 8'h02, 8'h00);
    wb(1'b1, idx_tab[0], 8'h04, 8'h00);
    run <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      wait_valid(600, n);
      repeat (3) @(posedge clock_in);
      ones = count_ones(p * 125, 125, d);
      r = 16'(2 * ones - 125);
      check("irq", 32'(p == 0), 32'(irq));
      wb(1'b0, idx_tab[2], 8'h00, r[15:8]);
      wb(1'b0, idx_tab[3], 8'h00, r[7:0]);
      wb(1'b0, idx_tab[4], 8'h00, 8'(ones));
      wb(1'b0, idx_tab[0], 8'h00, 8'h04);
      wb(1'b1, idx_tab[0], 8'h04, 8'h00);
      wb(1'b0, idx_tab[0], 8'h00, 8'h00);
      wb(1'b1, idx_tab[1], 8'h04, 8'h00);
      check("irq", 32'h0000_0000, 32'(irq));
    end
    // result period per rate code, strobe to strobe
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, idx_tab[5], {5'h01, 3'(c)}, 8'h00);
      wait_valid(40000, n);
      wait_valid(40000, n);
      check("rate gap", 32'(div_tab[c]), 32'(n));
    end
    wb(1'b1, idx_tab[5], 8'h00, 8'h00);
    for (int k = 2; k < 5; k++) wb(1'b0, idx_tab[k], 8'h00, 8'h00);
    run <= 1'b0;
    tally_and_finish();
  end
endmodule : tb
